//--- fan_cfg4_block.sv
// Lockable pin/sense configuration register and two factory test registers
`include "fan_cfg4_regs.svh"
`default_nettype none
// Functional notes
// - Bits 1:0 route shared pin: tach, thermal alarm, bus alert, GPIO.
// - Config register resets to 0x00: pin is fan 4 tach input from the first clock after reset; cfg is all zeros during reset.
// - Bits 3:2 pick two-wire tach threshold, low frequency drive only.
// - Bit 5 set bypasses core-voltage attenuator, full scale 2.2965 V.
// - Global lock set makes config register read-only; writes ignored.
// - First test register is read-only, reads 0x00 after reset.
// - Second test register is read-only, reads 0x00 after reset.
// - Drive frequency bit: 0 high frequency, 1 low frequency drive.
module fan_cfg4_block
	import fan_cfg4_pkg::*;
(
	// Clock and reset
	input  wire logic     clk,
	input  wire logic     resetn,
	// Register access from the serial bus engine
	input  wire reg_req_s req,
	output var  reg_rsp_s rsp,
	// Lock and drive mode from other config registers
	input  wire logic     global_lock,
	input  wire logic     fan_drive_frequency_select,
	// Decoded configuration to the pin mux and measurement logic
	output var  pin_cfg_s cfg
);

	typedef struct packed {
		logic [7:0] config_reg;
		logic       rd_pend;
		logic       rd_test;
		logic [7:0] rd_hold;
		reg_rsp_s   rsp;
		pin_cfg_s   cfg;
	} state_s;

	state_s     s_q;
	state_s     s_d;
	logic       test_sel;
	logic [7:0] test_rdata;

	function automatic pin_cfg_s decode(input logic [7:0] r, input logic lf);
		pin_cfg_s c;
		c.shared_pin_function_select     = pin_func_e'(r[`PIN_FUNC_LSB +: 2]);
		c.two_wire_tach_threshold        = tach_thr_e'(r[`TACH_THR_LSB +: 2]);
		c.core_voltage_attenuator_bypass = r[`ATT_BYPASS_BIT];
		c.tach_threshold_active          = lf;
		c.sel_fan4_speed_input  = (c.shared_pin_function_select == PIN_FAN4_TACH);
		c.sel_thermal_alarm_pin = (c.shared_pin_function_select == PIN_THERMAL_ALARM);
		c.sel_smbus_alert       = (c.shared_pin_function_select == PIN_SMBUS_ALERT);
		c.sel_gpio              = (c.shared_pin_function_select == PIN_GPIO);
		return c;
	endfunction

	assign test_sel = req.rd_en &&
		(req.addr == `FACTORY_TEST_ONE_ADDR || req.addr == `FACTORY_TEST_TWO_ADDR);

	factory_test_regs u_test (
		.clk    (clk),
		.resetn (resetn),
		.sel    (test_sel),
		.idx    (req.addr[0] == 1'b1 ? 1'b1 : 1'b0),
		.rdata  (test_rdata)
	);

	always_comb begin
		s_d = s_q;
		s_d.rsp.rvalid = 1'b0;
		s_d.rd_pend = 1'b0;
		// Writes to the test registers fall through untouched
		if (req.wr_en && req.addr == `PIN_SENSE_CONFIG_ADDR && !global_lock) begin
			s_d.config_reg = req.wdata & `PIN_SENSE_CONFIG_MASK;
		end
		if (req.rd_en) begin
			s_d.rd_pend = 1'b1;
			s_d.rd_test = test_sel;
			s_d.rd_hold = (req.addr == `PIN_SENSE_CONFIG_ADDR) ? s_q.config_reg : 8'h00;
		end
		// Answer one cycle after the test memory's registered read
		if (s_q.rd_pend) begin
			s_d.rsp.rvalid = 1'b1;
			s_d.rsp.rdata  = s_q.rd_test ? test_rdata : s_q.rd_hold;
		end
		s_d.cfg = decode(s_d.config_reg, fan_drive_frequency_select);
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_q.config_reg <= `PIN_SENSE_CONFIG_RESET;
			s_q.rd_pend    <= 1'b0;
			s_q.rd_test    <= 1'b0;
			s_q.rd_hold    <= 8'h00;
			s_q.rsp        <= '0;
			s_q.cfg        <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rsp = s_q.rsp;
	assign cfg = s_q.cfg;

endmodule
`default_nettype wire

//--- fan_cfg4_regs.svh
// Register offsets, field positions, reset values for the pin and sense config slice
`ifndef FAN_CFG4_REGS_SVH
`define FAN_CFG4_REGS_SVH

`define PIN_SENSE_CONFIG_ADDR 8'h7d
`define FACTORY_TEST_ONE_ADDR 8'h7e
`define FACTORY_TEST_TWO_ADDR 8'h7f

`define PIN_SENSE_CONFIG_RESET 8'h00
`define FACTORY_TEST_RESET     8'h00
`define PIN_SENSE_CONFIG_MASK  8'h2f

`define PIN_FUNC_LSB   0
`define TACH_THR_LSB   2
`define ATT_BYPASS_BIT 5

`endif

//--- fan_cfg4_pkg.sv
// Types for the pin and sense config register slice
`default_nettype none
package fan_cfg4_pkg;

	typedef enum logic [1:0] {
		PIN_FAN4_TACH,
		PIN_THERMAL_ALARM,
		PIN_SMBUS_ALERT,
		PIN_GPIO
	} pin_func_e;

	typedef enum logic [1:0] {
		THR_20MV,
		THR_40MV,
		THR_80MV,
		THR_130MV
	} tach_thr_e;

	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic       rvalid;
		logic [7:0] rdata;
	} reg_rsp_s;

	typedef struct packed {
		pin_func_e shared_pin_function_select;
		tach_thr_e two_wire_tach_threshold;
		logic      core_voltage_attenuator_bypass;
		logic      tach_threshold_active;
		logic      sel_fan4_speed_input;
		logic      sel_thermal_alarm_pin;
		logic      sel_smbus_alert;
		logic      sel_gpio;
	} pin_cfg_s;

endpackage
`default_nettype wire

//--- factory_test_regs.sv
// Two read-only factory test bytes with registered read data
`include "fan_cfg4_regs.svh"
`default_nettype none
module factory_test_regs
	import fan_cfg4_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Read port
	input  wire logic       sel,
	input  wire logic       idx,
	output var  logic [7:0] rdata
);

	typedef struct packed {
		logic [1:0][7:0] mem;
		logic [7:0]      rdata;
	} state_s;

	state_s s_q;
	state_s s_d;

	always_comb begin
		s_d = s_q;
		// Contents never change; only the read register moves
		if (sel) begin
			s_d.rdata = s_q.mem[idx];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_q.mem[0] <= `FACTORY_TEST_RESET;
			s_q.mem[1] <= `FACTORY_TEST_RESET;
			s_q.rdata  <= 8'h00;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;

endmodule
`default_nettype wire

//--- fan_cfg4_assertions.sv
// Port checks for the config and test register slice
`default_nettype none
module fan_cfg4_assertions import fan_cfg4_pkg::*; (
	// Clock and reset
	input wire logic     clk,
	input wire logic     resetn,
	// Watched ports
	input wire reg_req_s req,
	input wire reg_rsp_s rsp,
	input wire logic     global_lock,
	input wire logic     fan_drive_frequency_select,
	input wire pin_cfg_s cfg
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire logic wc = req.wr_en && req.addr == 8'h7d && !global_lock;
	chk_pin_route: assert property (wc |=> cfg.shared_pin_function_select == $past(req.wdata[1:0]))
		else $error("pin function");
	chk_reset_cfg: assert property ($rose(resetn) |-> cfg[9:4] == 6'h00)
		else $error("reset value");
	chk_tach_thr: assert property (wc |=> cfg.two_wire_tach_threshold == $past(req.wdata[3:2]))
		else $error("threshold");
	chk_att_bypass: assert property (wc |=> cfg.core_voltage_attenuator_bypass == $past(req.wdata[5]))
		else $error("bypass");
	chk_lock_hold: assert property (global_lock && req.wr_en |=> $stable(cfg[9:5]))
		else $error("locked write");
	chk_test_zero: assert property (req.rd_en && req.addr[7:1] == 7'h3f |-> ##2 rsp == 9'h100)
		else $error("test reg");
	chk_drive_mode: assert property ($past(resetn) |-> cfg.tach_threshold_active == $past(fan_drive_frequency_select))
		else $error("drive mode");
	chk_unused_zero: assert property (req.rd_en && req.addr == 8'h7d |-> ##2 rsp.rvalid && !rsp.rdata[7] && !rsp.rdata[6] && !rsp.rdata[4])
		else $error("unused bits");
endmodule
bind fan_cfg4_block fan_cfg4_assertions u_fan_cfg4_assertions (.clk(clk), .resetn(resetn),
	.req(req), .rsp(rsp), .global_lock(global_lock),
	.fan_drive_frequency_select(fan_drive_frequency_select), .cfg(cfg));
`default_nettype wire

//--- fan_cfg4_block_tb.sv
// Self-checking bench for the config and test register slice
`default_nettype none
module fan_cfg4_block_tb import fan_cfg4_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic     clk = 0;
	logic     resetn = 0;
	reg_req_s req = '0;
	reg_rsp_s rsp;
	logic     global_lock = 0;
	logic     fan_drive_frequency_select = 0;
	pin_cfg_s cfg;
	logic [7:0] d;
	int       failures = 0;
	int       cmp_count = 0;
	always #25 clk = ~clk;
	fan_cfg4_block u_fan_cfg4_block (.clk(clk), .resetn(resetn), .req(req), .rsp(rsp),
		.global_lock(global_lock), .fan_drive_frequency_select(fan_drive_frequency_select),
		.cfg(cfg));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		req = '{1'b1, 1'b0, a, v};
		@(negedge clk);
		req.wr_en = 0;
	endtask
	// Waits a bounded time for the answer, then compares it
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		req.rd_en = 0;
		for (int n = 0; n < 4 && rsp.rvalid !== 1'b1; n++) @(negedge clk);
		if (rsp.rvalid !== 1'b1) begin
			failures++;
			final_report();
		end
		chk(rsp.rdata, e);
	endtask
	initial begin
		repeat (20) @(negedge clk);
		resetn = 1;
		rd(8'h7d, 8'h00);
		rd(8'h7e, 8'h00);
		rd(8'h7f, 8'h00);
		rd(8'h10, 8'h00);
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			d = 8'(i * 5) | (8'(i % 2) << 5);
			wr(8'h7d, d | 8'hd0);
			rd(8'h7d, d);
			chk({4'h0, cfg[3:0]}, 8'h08 >> i);
			chk({2'b00, cfg[5], 1'b0, cfg[7:6], cfg[9:8]}, d);
		end
		$display("field test done");
		global_lock = 1;
		wr(8'h7d, 8'h00);
		rd(8'h7d, 8'h2f);
		global_lock = 0;
		// Host stays off the test registers; stray write goes to an unmapped offset
		wr(8'h10, 8'hff);
		rd(8'h7f, 8'h00);
		fan_drive_frequency_select = 1;
		repeat (2) @(negedge clk);
		chk({7'h00, cfg.tach_threshold_active}, 8'h01);
		$display("lock and mode test done");
		final_report();
	end
endmodule
`default_nettype wire
